//--- design/video_crop_pkg.sv
package video_crop_pkg;

    localparam int COUNT_W = 12;
    localparam int DROP_W = 6;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Byte addresses of the register words.
    localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;
    localparam logic [ADDR_W-1:0] HWIN_OFFSET = 8'h04;
    localparam logic [ADDR_W-1:0] VWIN_OFFSET = 8'h08;
    localparam logic [ADDR_W-1:0] DECIM_OFFSET = 8'h0C;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h10;

    // Field positions inside the register words.
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_HPOL_BIT = 1;
    localparam int CTRL_VPOL_BIT = 2;
    localparam int WIN_FIRST_LSB = 0;
    localparam int WIN_LAST_LSB = 16;
    localparam int DECIM_H_LSB = 0;
    localparam int DECIM_V_LSB = 8;
    localparam int STATUS_COUNT_W = 16;
    localparam int STATUS_BUSY_BIT = 16;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Decimation drops a programmed count out of every run of this many.
    localparam logic [DROP_W:0] DECIM_RUN = 7'h40;
    localparam logic [COUNT_W-1:0] COUNT_MAX = 12'hFFF;

    typedef struct packed {
        logic enable;
        logic hsync_polarity_select;
        logic vsync_polarity_select;
        logic [COUNT_W-1:0] h_sample_first;
        logic [COUNT_W-1:0] h_sample_last;
        logic [COUNT_W-1:0] v_sample_first;
        logic [COUNT_W-1:0] v_sample_last;
        logic [DROP_W-1:0] h_drop_count;
        logic [DROP_W-1:0] v_drop_count;
    } crop_cfg_t;

    localparam crop_cfg_t CFG_RESET = '0;

    typedef struct packed {
        logic [7:0] luma;
        logic [7:0] chroma;
    } pixel_t;

endpackage : video_crop_pkg

//--- design/video_input_crop_window.sv
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps

module video_input_crop_window (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [video_crop_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [video_crop_pkg::DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [video_crop_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [video_crop_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic pix_clk,
    input wire logic hsync,
    input wire logic vsync,
    input wire video_crop_pkg::pixel_t pix_in,
    output logic out_valid,
    output video_crop_pkg::pixel_t out_pixel,
    output logic out_field_start
);

    function automatic logic [video_crop_pkg::DROP_W:0] decim_step(
        input logic [video_crop_pkg::DROP_W-1:0] acc,
        input logic [video_crop_pkg::DROP_W-1:0] drop
    );
        logic [video_crop_pkg::DROP_W:0] sum;
        sum = {1'b0, acc} + {1'b0, drop};
        if (sum >= video_crop_pkg::DECIM_RUN)
        begin
            sum = sum - video_crop_pkg::DECIM_RUN;
            return {1'b1, sum[video_crop_pkg::DROP_W-1:0]};
        end
        return {1'b0, sum[video_crop_pkg::DROP_W-1:0]};
    endfunction : decim_step

    function automatic logic in_window(
        input logic [video_crop_pkg::COUNT_W-1:0] count,
        input logic [video_crop_pkg::COUNT_W-1:0] first,
        input logic [video_crop_pkg::COUNT_W-1:0] last
    );
        return (count >= first) && (count <= last);
    endfunction : in_window

    logic [1:0] ref_rst_sync;
    logic ref_rst_n;
    logic [1:0] pix_rst_sync;
    logic pix_rst_n;

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            ref_rst_sync <= 2'h0;
        else
            ref_rst_sync <= {ref_rst_sync[0], 1'b1};
    end
    assign ref_rst_n = ref_rst_sync[1];

    always_ff @(posedge pix_clk or negedge reset_n)
    begin
        if (!reset_n)
            pix_rst_sync <= 2'h0;
        else
            pix_rst_sync <= {pix_rst_sync[0], 1'b1};
    end
    assign pix_rst_n = pix_rst_sync[1];

    // Register bus side.
    video_crop_pkg::crop_cfg_t cfg, next_cfg;
    video_crop_pkg::crop_cfg_t xfer_cfg, next_xfer_cfg;
    logic aw_held, next_aw_held, w_held, next_w_held;
    logic [video_crop_pkg::ADDR_W-1:0] aw_addr, next_aw_addr;
    logic [video_crop_pkg::DATA_W-1:0] w_data, next_w_data;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [video_crop_pkg::DATA_W-1:0] next_rdata;
    logic dirty, next_dirty, req_tog, next_req_tog;
    logic [2:0] ack_sync;
    logic ack_stable, busy;
    logic [2:0] fld_sync;
    logic fld_stable, fld_seen, next_fld_seen;
    logic [video_crop_pkg::STATUS_COUNT_W-1:0] field_count, next_field_count;
    logic ack_tog, field_tog;

    assign busy = req_tog != ack_stable;

    always_comb
    begin
        logic [video_crop_pkg::DATA_W-1:0] rd;
        logic do_write;
        rd = '0;
        do_write = 1'b0;
        next_cfg = cfg;
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rresp = rresp;
        next_rdata = rdata;
        next_dirty = dirty;
        next_req_tog = req_tog;
        next_xfer_cfg = xfer_cfg;
        next_fld_seen = fld_seen;
        next_field_count = field_count;
        if (awvalid && awready)
        begin
            next_aw_held = 1'b1;
            next_aw_addr = awaddr;
        end
        if (wvalid && wready)
        begin
            next_w_held = 1'b1;
            next_w_data = wdata;
        end
        if (bvalid && bready)
            next_bvalid = 1'b0;
        if (next_aw_held && next_w_held && !bvalid)
        begin
            do_write = 1'b1;
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = video_crop_pkg::RESP_OKAY;
            case (next_aw_addr)
                video_crop_pkg::CTRL_OFFSET:
                begin
                    next_cfg.enable =
                        next_w_data[video_crop_pkg::CTRL_ENABLE_BIT];
                    next_cfg.hsync_polarity_select =
                        next_w_data[video_crop_pkg::CTRL_HPOL_BIT];
                    next_cfg.vsync_polarity_select =
                        next_w_data[video_crop_pkg::CTRL_VPOL_BIT];
                end
                video_crop_pkg::HWIN_OFFSET:
                begin
                    next_cfg.h_sample_first = next_w_data[
                        video_crop_pkg::WIN_FIRST_LSB +:
                        video_crop_pkg::COUNT_W];
                    next_cfg.h_sample_last = next_w_data[
                        video_crop_pkg::WIN_LAST_LSB +:
                        video_crop_pkg::COUNT_W];
                end
                video_crop_pkg::VWIN_OFFSET:
                begin
                    next_cfg.v_sample_first = next_w_data[
                        video_crop_pkg::WIN_FIRST_LSB +:
                        video_crop_pkg::COUNT_W];
                    next_cfg.v_sample_last = next_w_data[
                        video_crop_pkg::WIN_LAST_LSB +:
                        video_crop_pkg::COUNT_W];
                end
                video_crop_pkg::DECIM_OFFSET:
                begin
                    next_cfg.h_drop_count = next_w_data[
                        video_crop_pkg::DECIM_H_LSB +:
                        video_crop_pkg::DROP_W];
                    next_cfg.v_drop_count = next_w_data[
                        video_crop_pkg::DECIM_V_LSB +:
                        video_crop_pkg::DROP_W];
                end
                video_crop_pkg::STATUS_OFFSET:
                    do_write = 1'b0;
                default:
                begin
                    do_write = 1'b0;
                    next_bresp = video_crop_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (rvalid && rready)
            next_rvalid = 1'b0;
        if (arvalid && arready)
        begin
            next_rvalid = 1'b1;
            next_rresp = video_crop_pkg::RESP_OKAY;
            case (araddr)
                video_crop_pkg::CTRL_OFFSET:
                begin
                    rd[video_crop_pkg::CTRL_ENABLE_BIT] = cfg.enable;
                    rd[video_crop_pkg::CTRL_HPOL_BIT] =
                        cfg.hsync_polarity_select;
                    rd[video_crop_pkg::CTRL_VPOL_BIT] =
                        cfg.vsync_polarity_select;
                end
                video_crop_pkg::HWIN_OFFSET:
                begin
                    rd[video_crop_pkg::WIN_FIRST_LSB +:
                        video_crop_pkg::COUNT_W] = cfg.h_sample_first;
                    rd[video_crop_pkg::WIN_LAST_LSB +:
                        video_crop_pkg::COUNT_W] = cfg.h_sample_last;
                end
                video_crop_pkg::VWIN_OFFSET:
                begin
                    rd[video_crop_pkg::WIN_FIRST_LSB +:
                        video_crop_pkg::COUNT_W] = cfg.v_sample_first;
                    rd[video_crop_pkg::WIN_LAST_LSB +:
                        video_crop_pkg::COUNT_W] = cfg.v_sample_last;
                end
                video_crop_pkg::DECIM_OFFSET:
                begin
                    rd[video_crop_pkg::DECIM_H_LSB +:
                        video_crop_pkg::DROP_W] = cfg.h_drop_count;
                    rd[video_crop_pkg::DECIM_V_LSB +:
                        video_crop_pkg::DROP_W] = cfg.v_drop_count;
                end
                video_crop_pkg::STATUS_OFFSET:
                begin
                    rd[video_crop_pkg::STATUS_COUNT_W-1:0] = field_count;
                    rd[video_crop_pkg::STATUS_BUSY_BIT] = busy | dirty;
                end
                default:
                    next_rresp = video_crop_pkg::RESP_SLVERR;
            endcase
            next_rdata = rd;
        end
        // A launch copies the settings; a write in the same cycle wins.
        if (dirty && !busy)
        begin
            next_xfer_cfg = cfg;
            next_req_tog = ~req_tog;
            next_dirty = 1'b0;
        end
        if (do_write)
            next_dirty = 1'b1;
        if (fld_stable != fld_seen)
        begin
            next_fld_seen = fld_stable;
            next_field_count = field_count + 1'b1;
        end
        next_awready = !next_aw_held && !next_bvalid;
        next_wready = !next_w_held && !next_bvalid;
        next_arready = !next_rvalid;
    end

    always_ff @(posedge ref_clk or negedge ref_rst_n)
    begin
        if (!ref_rst_n)
        begin
            cfg <= video_crop_pkg::CFG_RESET;
            xfer_cfg <= video_crop_pkg::CFG_RESET;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= video_crop_pkg::RESP_OKAY;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rresp <= video_crop_pkg::RESP_OKAY;
            rdata <= '0;
            dirty <= 1'b0;
            req_tog <= 1'b0;
            ack_sync <= 3'h0;
            ack_stable <= 1'b0;
            fld_sync <= 3'h0;
            fld_stable <= 1'b0;
            fld_seen <= 1'b0;
            field_count <= '0;
        end
        else
        begin
            cfg <= next_cfg;
            xfer_cfg <= next_xfer_cfg;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            awready <= next_awready;
            wready <= next_wready;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            arready <= next_arready;
            rvalid <= next_rvalid;
            rresp <= next_rresp;
            rdata <= next_rdata;
            dirty <= next_dirty;
            req_tog <= next_req_tog;
            ack_sync <= {ack_sync[1:0], ack_tog};
            if (ack_sync[2] == ack_sync[1])
                ack_stable <= ack_sync[2];
            fld_sync <= {fld_sync[1:0], field_tog};
            if (fld_sync[2] == fld_sync[1])
                fld_stable <= fld_sync[2];
            fld_seen <= next_fld_seen;
            field_count <= next_field_count;
        end
    end

    // Pixel clock side. The settings word is held still while the request
    // toggle is outstanding, so it may be sampled here without tearing.
    video_crop_pkg::crop_cfg_t pcfg, next_pcfg;
    logic [2:0] req_sync;
    logic req_stable, next_ack_tog;
    logic hs_r, vs_r, h_prev, v_prev, next_h_prev, next_v_prev;
    video_crop_pkg::pixel_t px_r;
    logic [video_crop_pkg::COUNT_W-1:0] pix_cnt, next_pix_cnt;
    logic [video_crop_pkg::COUNT_W-1:0] line_cnt, next_line_cnt;
    logic [video_crop_pkg::DROP_W-1:0] h_acc, next_h_acc, v_acc, next_v_acc;
    logic line_keep, next_line_keep, field_en, next_field_en;
    logic field_hit, next_field_hit, next_field_tog;
    logic next_out_valid, next_out_field_start;
    video_crop_pkg::pixel_t next_out_pixel;

    always_comb
    begin
        logic h_act, v_act, h_edge, v_edge;
        logic [video_crop_pkg::DROP_W:0] hstep, vstep;
        next_pcfg = pcfg;
        next_ack_tog = ack_tog;
        if (req_stable != ack_tog)
        begin
            next_pcfg = xfer_cfg;
            next_ack_tog = req_stable;
        end
        h_act = pcfg.hsync_polarity_select ? hs_r : ~hs_r;
        v_act = pcfg.vsync_polarity_select ? vs_r : ~vs_r;
        h_edge = h_act && !h_prev;
        v_edge = v_act && !v_prev;
        next_h_prev = h_act;
        next_v_prev = v_act;
        next_pix_cnt = h_edge ? '0 :
            (pix_cnt == video_crop_pkg::COUNT_MAX) ? pix_cnt :
            pix_cnt + 1'b1;
        next_line_cnt = v_edge ? '0 :
            (h_edge && line_cnt != video_crop_pkg::COUNT_MAX) ?
            line_cnt + 1'b1 : line_cnt;
        next_field_en = v_edge ? pcfg.enable : field_en;
        next_field_hit = v_edge ? 1'b0 : field_hit;
        next_field_tog = field_tog;
        if (v_edge && field_hit)
            next_field_tog = ~field_tog;
        next_out_field_start = v_edge && pcfg.enable;
        next_v_acc = v_edge ? '0 : v_acc;
        next_line_keep = v_edge ? 1'b0 : line_keep;
        vstep = decim_step(next_v_acc, pcfg.v_drop_count);
        if (h_edge)
        begin
            next_line_keep = 1'b0;
            if (next_field_en && in_window(next_line_cnt,
                pcfg.v_sample_first, pcfg.v_sample_last))
            begin
                next_v_acc = vstep[video_crop_pkg::DROP_W-1:0];
                next_line_keep = !vstep[video_crop_pkg::DROP_W];
            end
        end
        next_h_acc = h_edge ? '0 : h_acc;
        hstep = decim_step(next_h_acc, pcfg.h_drop_count);
        next_out_valid = 1'b0;
        next_out_pixel = out_pixel;
        // Inclusive bounds keep last minus first plus one pixels.
        if (next_line_keep && in_window(next_pix_cnt,
            pcfg.h_sample_first, pcfg.h_sample_last))
        begin
            next_h_acc = hstep[video_crop_pkg::DROP_W-1:0];
            // Only dropping is possible, so output never outgrows input.
            next_out_valid = !hstep[video_crop_pkg::DROP_W];
            if (next_out_valid)
            begin
                next_out_pixel = px_r;
                next_field_hit = 1'b1;
            end
        end
    end

    always_ff @(posedge pix_clk or negedge pix_rst_n)
    begin
        if (!pix_rst_n)
        begin
            pcfg <= video_crop_pkg::CFG_RESET;
            req_sync <= 3'h0;
            req_stable <= 1'b0;
            ack_tog <= 1'b0;
            hs_r <= 1'b0;
            vs_r <= 1'b0;
            px_r <= '0;
            h_prev <= 1'b1;
            v_prev <= 1'b1;
            pix_cnt <= '0;
            line_cnt <= '0;
            h_acc <= '0;
            v_acc <= '0;
            line_keep <= 1'b0;
            field_en <= 1'b0;
            field_hit <= 1'b0;
            field_tog <= 1'b0;
            out_valid <= 1'b0;
            out_pixel <= '0;
            out_field_start <= 1'b0;
        end
        else
        begin
            pcfg <= next_pcfg;
            req_sync <= {req_sync[1:0], req_tog};
            if (req_sync[2] == req_sync[1])
                req_stable <= req_sync[2];
            ack_tog <= next_ack_tog;
            hs_r <= hsync;
            vs_r <= vsync;
            px_r <= pix_in;
            h_prev <= next_h_prev;
            v_prev <= next_v_prev;
            pix_cnt <= next_pix_cnt;
            line_cnt <= next_line_cnt;
            h_acc <= next_h_acc;
            v_acc <= next_v_acc;
            line_keep <= next_line_keep;
            field_en <= next_field_en;
            field_hit <= next_field_hit;
            field_tog <= next_field_tog;
            out_valid <= next_out_valid;
            out_pixel <= next_out_pixel;
            out_field_start <= next_out_field_start;
        end
    end

endmodule : video_input_crop_window

//--- tb/video_crop_sva.sv
`timescale 1ns/100ps
module video_crop_sva (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic awready,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic pix_clk,
    input wire logic vsync,
    input wire video_crop_pkg::pixel_t pix_in,
    input wire logic out_valid,
    input wire video_crop_pkg::pixel_t out_pixel,
    input wire logic out_field_start
);
    property p_b_hold; @(posedge ref_clk) disable iff (!reset_n)
        bvalid && !bready |=> bvalid && $stable(bresp); endproperty
    a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
    property p_r_hold; @(posedge ref_clk) disable iff (!reset_n)
        rvalid && !rready |=> rvalid && $stable({rdata, rresp}); endproperty
    a_r_hold: assert property (p_r_hold) else $error("rvalid dropped");
    property p_r_answer; @(posedge ref_clk) disable iff (!reset_n)
        arvalid && arready |=> rvalid; endproperty
    a_r_answer: assert property (p_r_answer) else $error("read late");
    property p_w_refuse; @(posedge ref_clk) disable iff (!reset_n)
        bvalid |-> !awready && !wready; endproperty
    a_w_refuse: assert property (p_w_refuse) else $error("write taken");
    property p_ar_refuse; @(posedge ref_clk) disable iff (!reset_n)
        rvalid |-> !arready; endproperty
    a_ar_refuse: assert property (p_ar_refuse) else $error("read taken");
    property p_pix_delay; @(posedge pix_clk) disable iff (!reset_n)
        out_valid |-> out_pixel == $past(pix_in, 2); endproperty
    a_pix_delay: assert property (p_pix_delay) else $error("pixel");
    property p_pix_hold; @(posedge pix_clk) disable iff (!reset_n)
        !out_valid |-> $stable(out_pixel); endproperty
    a_pix_hold: assert property (p_pix_hold) else $error("hold");
    property p_field; @(posedge pix_clk) disable iff (!reset_n)
        out_field_start |-> $past(vsync, 2) != $past(vsync, 3); endproperty
    a_field: assert property (p_field) else $error("field start");
endmodule : video_crop_sva

bind video_input_crop_window video_crop_sva i_sva (
    .ref_clk(ref_clk), .reset_n(reset_n), .awready(awready),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .pix_clk(pix_clk), .vsync(vsync),
    .pix_in(pix_in), .out_valid(out_valid), .out_pixel(out_pixel),
    .out_field_start(out_field_start)
);

//--- tb/video_source_model.sv
`timescale 1ns/100ps
module video_source_model #(
    parameter int LINE_LEN = 80
) (
    input wire logic pix_clk,
    input wire logic h_pol,
    input wire logic v_pol,
    output logic hsync,
    output logic vsync,
    output video_crop_pkg::pixel_t pix_in
);
    logic h_act = 1'b0;
    logic v_act = 1'b0;
    logic [7:0] line_idx = 8'h00;
    logic [7:0] px_idx = 8'h00;
    // Syncs rest at the inactive level, so a polarity flip makes an edge.
    assign hsync = h_act ? h_pol : ~h_pol;
    assign vsync = v_act ? v_pol : ~v_pol;
    // Each pixel carries its own line and position for the checks.
    assign pix_in = {line_idx, px_idx};
    task send_field(input int n_lines);
        int l;
        int p;
        for (p = 0; p < 8; p++)
        begin
            @(posedge pix_clk);
            v_act <= (p < 3);
        end
        for (l = 1; l <= n_lines; l++)
            for (p = 0; p < LINE_LEN; p++)
            begin
                @(posedge pix_clk);
                h_act <= (p < 4);
                line_idx <= 8'(l);
                px_idx <= 8'(p);
            end
    endtask : send_field
endmodule : video_source_model

//--- tb/testbench.sv
`timescale 1ns/100ps
module testbench;
    logic ref_clk, reset_n, pix_clk, awvalid, wvalid, bready, arvalid;
    logic rready, awready, wready, bvalid, arready, rvalid, hsync, vsync;
    logic out_valid, out_field_start, h_pol, v_pol;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    video_crop_pkg::pixel_t pix_in, out_pixel;
    logic [15:0] got_q[$];
    logic [15:0] exp_q[$];
    int n_errors, num_checks, i;
    video_input_crop_window i_dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .pix_clk(pix_clk), .hsync(hsync), .vsync(vsync),
        .pix_in(pix_in), .out_valid(out_valid), .out_pixel(out_pixel),
        .out_field_start(out_field_start)
    );
    video_source_model i_src (.pix_clk(pix_clk), .h_pol(h_pol),
        .v_pol(v_pol), .hsync(hsync), .vsync(vsync), .pix_in(pix_in));
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // The odd offset keeps the two clock edges from lining up.
    initial
    begin
        pix_clk = 1'b0;
        #1.3;
        forever #3 pix_clk = ~pix_clk;
    end
    always @(posedge pix_clk) if (out_valid === 1'b1) got_q.push_back(out_pixel);
    task complete_run();
        $display("checks %0d, mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run
    task timeout();
        n_errors++;
        complete_run();
    endtask : timeout
    task check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            n_errors++;
        end
    endtask : check
    task axi_write(input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (k = 0; k < 200; k++)
        begin
            @(posedge ref_clk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        if (k == 200) timeout();
        resp = bresp;
        bready <= 1'b0;
    endtask : axi_write
    task axi_read(input logic [7:0] a);
        int k;
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (k = 0; k < 200; k++)
        begin
            @(posedge ref_clk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        if (k == 200) timeout();
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : axi_read
    // Settings cross to the pixel side; wait until the handover is done.
    task settle();
        int k;
        for (k = 0; k < 50; k++)
        begin
            axi_read(video_crop_pkg::STATUS_OFFSET);
            if (rd[video_crop_pkg::STATUS_BUSY_BIT] === 1'b0) break;
        end
        if (k == 50) timeout();
    endtask : settle
    task run_field(input logic [31:0] ctrl, input int hf, hl, vf, vl, hd,
        vd, nl);
        int l, p, hacc, vacc, j;
        axi_write(video_crop_pkg::HWIN_OFFSET, 32'(hl) << 16 | 32'(hf));
        axi_write(video_crop_pkg::VWIN_OFFSET, 32'(vl) << 16 | 32'(vf));
        axi_write(video_crop_pkg::DECIM_OFFSET, 32'(vd) << 8 | 32'(hd));
        axi_write(video_crop_pkg::CTRL_OFFSET, ctrl);
        settle();
        axi_read(video_crop_pkg::HWIN_OFFSET);
        check(rd, 32'(hl) << 16 | 32'(hf));
        exp_q.delete();
        vacc = 0;
        for (l = 1; l <= nl; l++)
            if (ctrl[0] && l >= vf && l <= vl)
            begin
                hacc = 0;
                if (vacc + vd < 64)
                    for (p = hf; p <= hl; p++)
                    begin
                        if (hacc + hd < 64) exp_q.push_back({l[7:0], p[7:0]});
                        hacc = (hacc + hd) % 64;
                    end
                vacc = (vacc + vd) % 64;
            end
        got_q.delete();
        i_src.send_field(nl);
        repeat (6) @(posedge pix_clk);
        check(32'(got_q.size()), 32'(exp_q.size()));
        for (j = 0; j < exp_q.size() && j < got_q.size(); j++)
            check(32'(got_q[j]), 32'(exp_q[j]));
        $display("field test done, %0d pixels", exp_q.size());
    endtask : run_field
    initial
    begin
        reset_n = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, h_pol, v_pol} = '0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0000_0000;
        wstrb = 4'hF;
        n_errors = 0;
        num_checks = 0;
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (8) @(posedge ref_clk);
        for (i = 0; i < 5; i++)
        begin
            axi_read(8'(4 * i));
            check({rd, 30'h0000_0000, resp}, {32'h0000_0000, 32'h0000_0000});
        end
        axi_read(8'h20);
        check({rd, 30'h0000_0000, resp}, {32'h0000_0000, 32'h0000_0002});
        axi_write(8'h20, 32'h1234_5678);
        check(32'(resp), 32'(video_crop_pkg::RESP_SLVERR));
        axi_write(video_crop_pkg::STATUS_OFFSET, 32'hFFFF_FFFF);
        check(32'(resp), 32'(video_crop_pkg::RESP_OKAY));
        $display("register test done");
        run_field(32'h0000_0001, 0, 0, 1, 1, 0, 0, 3);
        // Polarity flips only while disabled, so stray edges output nothing.
        axi_write(video_crop_pkg::CTRL_OFFSET, 32'h0000_0006);
        settle();
        @(posedge pix_clk);
        h_pol <= 1'b1;
        v_pol <= 1'b1;
        repeat (10) @(posedge pix_clk);
        run_field(32'h0000_0007, 5, 74, 2, 7, 0, 0, 9);
        run_field(32'h0000_0007, 5, 74, 2, 7, 10, 32, 9);
        run_field(32'h0000_0006, 0, 0, 1, 1, 0, 0, 3);
        axi_read(video_crop_pkg::STATUS_OFFSET);
        check(rd, 32'h0000_0003);
        complete_run();
    end
endmodule : testbench
